// ==== rtl/ppgc_pkg.sv ====
// Constants, register layout and carrier types of the compare block
package ppgc_pkg;
  // Register byte offsets
  localparam logic [7:0] PPGC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] PPGC_OFS_STATUS = 8'h04;
  localparam logic [7:0] PPGC_OFS_U0     = 8'h10;
  localparam logic [7:0] PPGC_OFS_U1     = 8'h30;
  localparam logic [7:0] PPGC_OFS_PHASE  = 8'h24;
  // Word index of each compare inside a unit block
  localparam logic [2:0] PPGC_IDX_PERIOD = 3'h0;
  localparam logic [2:0] PPGC_IDX_RISE_A = 3'h1;
  localparam logic [2:0] PPGC_IDX_FALL_A = 3'h2;
  localparam logic [2:0] PPGC_IDX_RISE_B = 3'h3;
  localparam logic [2:0] PPGC_IDX_FALL_B = 3'h4;
  // Control field positions
  localparam int PPGC_CTRL_RUN0  = 0;
  localparam int PPGC_CTRL_RUN1  = 1;
  localparam int PPGC_CTRL_ILOCK = 2;
  localparam int PPGC_CTRL_SEL0  = 4;
  localparam int PPGC_CTRL_SEL1  = 6;
  localparam int PPGC_PHASE_LSB  = 1;
  // Widths
  localparam int PPGC_AW = 8;
  localparam int PPGC_CW = 16;
  // Reset values and counter limits
  localparam logic [7:0]  PPGC_RST_CTRL  = 8'h00;
  localparam logic [15:0] PPGC_RST_CMP   = 16'h0000;
  localparam logic [15:0] PPGC_CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] PPGC_CNT_START = 16'h0001;
  localparam logic [1:0]  PPGC_RESP_OKAY = 2'b00;
  localparam logic [1:0]  PPGC_RESP_SLVERR = 2'b10;

  // Event select codes
  typedef enum logic [1:0] {
    PPGC_SEL_NONE   = 2'b00,
    PPGC_SEL_PERIOD = 2'b01,
    PPGC_SEL_PHASE  = 2'b10,
    PPGC_SEL_OVF    = 2'b11
  } ppgc_sel_e;

  // The five compares of one unit
  typedef struct packed {
    logic [15:0] period;
    logic [15:0] rise_a;
    logic [15:0] fall_a;
    logic [15:0] rise_b;
    logic [15:0] fall_b;
  } ppgc_cmp_s;
endpackage

// ==== rtl/ppgc_unit.sv ====
// One timer unit: up counter, compare matches and two wave outputs
`timescale 1ns/1ps
module ppgc_unit (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               run,
  input  wire logic               wrap_en,
  input  wire logic               restart,
  input  wire ppgc_pkg::ppgc_cmp_s cmp,
  output logic [15:0]             cnt_q,
  output logic                    wave_a_q,
  output logic                    wave_b_q,
  output logic [4:0]              match
);
  logic [15:0] cnt_d;
  logic        wave_a_d;
  logic        wave_b_d;
  wire         at_period;
  wire         at_max;

  // Equality compares on the running count
  assign at_period = cnt_q == cmp.period;
  assign at_max    = cnt_q == ppgc_pkg::PPGC_CNT_MAX;
  assign match = run ? {cnt_q == cmp.fall_b, cnt_q == cmp.rise_b,
                        cnt_q == cmp.fall_a, cnt_q == cmp.rise_a,
                        at_period} : 5'h00;

  // Count 1..period so one period spans period clock cycles
  assign cnt_d = !run               ? 16'h0000 :
                 restart            ? ppgc_pkg::PPGC_CNT_START :
                 wrap_en && at_period ? ppgc_pkg::PPGC_CNT_START :
                 !wrap_en && at_max ? cnt_q :  // Slave holds at top
                 cnt_q + 16'h0001;

  // High from rise match to fall match gives the documented duty
  assign wave_a_d = !run ? 1'b0 : match[2] ? 1'b0 :
                    match[1] ? 1'b1 : wave_a_q;
  assign wave_b_d = !run ? 1'b0 : match[4] ? 1'b0 :
                    match[3] ? 1'b1 : wave_b_q;

  // Counter and wave registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q    <= 16'h0000;
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      wave_a_q <= wave_a_d;
      wave_b_q <= wave_b_d;
    end
  end

  period_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run && wrap_en && !restart && at_period |=>
    cnt_q == ppgc_pkg::PPGC_CNT_START)
    else $error("counter did not wrap at period");
  sat_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run && !wrap_en && !restart && at_max ##1 run && !restart |->
    at_max)
    else $error("slave counter left its ceiling");
  wave_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    match[1] && !match[2] |=> wave_a_q)
    else $error("wave a did not rise at its compare");
  wave_fall_a: assert property (@(posedge aclk) disable iff (!aresetn)
    match[2] |=> !wave_a_q)
    else $error("wave a did not fall at its compare");
endmodule  // ppgc_unit

// ==== rtl/ppgc_top.sv ====
// Two-unit pulse generator with event select, behind an AXI4-Lite slave
//
// Notes on behaviour
// - Phase field bits 16:1, below half period
// - Pulse mode period equals own period compare
// - Interlock period set by unit 0 only
// - Duty is fall minus rise over period
// - Unit 0 select: none, period, phase match
// - Unit 1 codes 00, 10, 11 give none
// - Unit 1 period event only in pulse mode
// - Four fixed match requests per unit
// - Interlock slave counter holds at 0xFFFF
// - Interlock: unit 0 settings win, others kept
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module ppgc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [3:0]       programmable_pulse_output,
  output logic             unit0_selectable_irq,
  output logic             unit1_selectable_irq,
  output logic [3:0]       unit0_fixed_irq,
  output logic [3:0]       unit1_fixed_irq
);
  // Merge write data into a 16-bit field at bit lsb under byte strobes
  function automatic logic [15:0] mrg(input logic [15:0] old,
                                      input logic [31:0] wd,
                                      input logic [3:0]  st,
                                      input int          lsb);
    logic [31:0] o;
    logic [31:0] m;
    o = {16'h0000, old} << lsb;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = st[i] ? wd[8*i +: 8] : o[8*i +: 8];
    end
    mrg = 16'(m >> lsb);
  endfunction

  // Address of a compare word inside a unit block
  function automatic logic [7:0] uaddr(input logic [7:0] base,
                                       input logic [2:0] idx);
    uaddr = base + {3'b000, idx, 2'b00};
  endfunction

  logic [7:0]          ctrl_q;
  logic [7:0]          ctrl_d;
  ppgc_pkg::ppgc_cmp_s u0_q, u0_d, u1_q, u1_d;
  logic [15:0]         phase_q;
  logic [15:0]         phase_d;
  logic                bvalid_q, arready_q, rvalid_q, awready_q;
  logic [1:0]          bresp_q, rresp_q;
  logic [31:0]         rdata_q;
  logic                irq_s0_q, irq_s1_q;
  logic [3:0]          irq_f0_q, irq_f1_q;
  logic [15:0]         cnt0, cnt1;
  logic [4:0]          m0, m1;

  // Bus decode
  wire [7:0] wa = {s_axi_awaddr[7:2], 2'b00};
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire wr_go  = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
  wire wr_hit = awready_q && s_axi_awvalid && s_axi_wvalid;
  wire rd_go  = s_axi_arvalid && !arready_q && !rvalid_q;
  wire rd_hit = arready_q && s_axi_arvalid;
  wire wr_ok  = wa == ppgc_pkg::PPGC_OFS_CTRL ||
                wa == ppgc_pkg::PPGC_OFS_PHASE ||
                (wa >= ppgc_pkg::PPGC_OFS_U0 &&
                 wa <= uaddr(ppgc_pkg::PPGC_OFS_U0, 3'h4)) ||
                (wa >= ppgc_pkg::PPGC_OFS_U1 &&
                 wa <= uaddr(ppgc_pkg::PPGC_OFS_U1, 3'h4));
  wire rd_ok  = ra == ppgc_pkg::PPGC_OFS_CTRL ||
                ra == ppgc_pkg::PPGC_OFS_STATUS ||
                ra == ppgc_pkg::PPGC_OFS_PHASE ||
                (ra >= ppgc_pkg::PPGC_OFS_U0 &&
                 ra <= uaddr(ppgc_pkg::PPGC_OFS_U0, 3'h4)) ||
                (ra >= ppgc_pkg::PPGC_OFS_U1 &&
                 ra <= uaddr(ppgc_pkg::PPGC_OFS_U1, 3'h4));

  // Control fields
  wire ilock = ctrl_q[ppgc_pkg::PPGC_CTRL_ILOCK];
  wire run0  = ctrl_q[ppgc_pkg::PPGC_CTRL_RUN0];
  wire [1:0] sel0 = ctrl_q[ppgc_pkg::PPGC_CTRL_SEL0 +: 2];
  wire [1:0] sel1 = ctrl_q[ppgc_pkg::PPGC_CTRL_SEL1 +: 2];
  // Interlock slaves unit 1 to the master run bit; own bit kept
  wire run1 = ilock ? run0 : ctrl_q[ppgc_pkg::PPGC_CTRL_RUN1];
  // Phase compare feeds unit 0 select and restarts unit 1 in interlock
  wire phase_hit = run0 && cnt0 == phase_q;

  // Next values of software registers
  always_comb begin
    ctrl_d  = ctrl_q;
    phase_d = phase_q;
    u0_d    = u0_q;
    u1_d    = u1_q;
    if (wr_hit) begin
      if (wa == ppgc_pkg::PPGC_OFS_CTRL) begin
        ctrl_d = 8'(mrg({8'h00, ctrl_q}, s_axi_wdata, s_axi_wstrb, 0));
      end
      if (wa == ppgc_pkg::PPGC_OFS_PHASE) begin
        phase_d = mrg(phase_q, s_axi_wdata, s_axi_wstrb,
                      ppgc_pkg::PPGC_PHASE_LSB);
      end
      if (wa == uaddr(ppgc_pkg::PPGC_OFS_U0, ppgc_pkg::PPGC_IDX_PERIOD))
        u0_d.period = mrg(u0_q.period, s_axi_wdata, s_axi_wstrb, 0);
      if (wa == uaddr(ppgc_pkg::PPGC_OFS_U0, ppgc_pkg::PPGC_IDX_RISE_A))
        u0_d.rise_a = mrg(u0_q.rise_a, s_axi_wdata, s_axi_wstrb, 0);
      if (wa == uaddr(ppgc_pkg::PPGC_OFS_U0, ppgc_pkg::PPGC_IDX_FALL_A))
        u0_d.fall_a = mrg(u0_q.fall_a, s_axi_wdata, s_axi_wstrb, 0);
      if (wa == uaddr(ppgc_pkg::PPGC_OFS_U0, ppgc_pkg::PPGC_IDX_RISE_B))
        u0_d.rise_b = mrg(u0_q.rise_b, s_axi_wdata, s_axi_wstrb, 0);
      if (wa == uaddr(ppgc_pkg::PPGC_OFS_U0, ppgc_pkg::PPGC_IDX_FALL_B))
        u0_d.fall_b = mrg(u0_q.fall_b, s_axi_wdata, s_axi_wstrb, 0);
      if (wa == uaddr(ppgc_pkg::PPGC_OFS_U1, ppgc_pkg::PPGC_IDX_PERIOD))
        u1_d.period = mrg(u1_q.period, s_axi_wdata, s_axi_wstrb, 0);
      if (wa == uaddr(ppgc_pkg::PPGC_OFS_U1, ppgc_pkg::PPGC_IDX_RISE_A))
        u1_d.rise_a = mrg(u1_q.rise_a, s_axi_wdata, s_axi_wstrb, 0);
      if (wa == uaddr(ppgc_pkg::PPGC_OFS_U1, ppgc_pkg::PPGC_IDX_FALL_A))
        u1_d.fall_a = mrg(u1_q.fall_a, s_axi_wdata, s_axi_wstrb, 0);
      if (wa == uaddr(ppgc_pkg::PPGC_OFS_U1, ppgc_pkg::PPGC_IDX_RISE_B))
        u1_d.rise_b = mrg(u1_q.rise_b, s_axi_wdata, s_axi_wstrb, 0);
      if (wa == uaddr(ppgc_pkg::PPGC_OFS_U1, ppgc_pkg::PPGC_IDX_FALL_B))
        u1_d.fall_b = mrg(u1_q.fall_b, s_axi_wdata, s_axi_wstrb, 0);
    end
  end

  // Read data selection; unmapped words read zero
  wire [31:0] rd_data =
    ra == ppgc_pkg::PPGC_OFS_CTRL   ? {24'h00_0000, ctrl_q} :
    ra == ppgc_pkg::PPGC_OFS_STATUS ? {cnt1, cnt0} :
    ra == ppgc_pkg::PPGC_OFS_PHASE  ? {15'h0000, phase_q, 1'b0} :
    ra == uaddr(ppgc_pkg::PPGC_OFS_U0, 3'h0) ? {16'h0000, u0_q.period} :
    ra == uaddr(ppgc_pkg::PPGC_OFS_U0, 3'h1) ? {16'h0000, u0_q.rise_a} :
    ra == uaddr(ppgc_pkg::PPGC_OFS_U0, 3'h2) ? {16'h0000, u0_q.fall_a} :
    ra == uaddr(ppgc_pkg::PPGC_OFS_U0, 3'h3) ? {16'h0000, u0_q.rise_b} :
    ra == uaddr(ppgc_pkg::PPGC_OFS_U0, 3'h4) ? {16'h0000, u0_q.fall_b} :
    ra == uaddr(ppgc_pkg::PPGC_OFS_U1, 3'h0) ? {16'h0000, u1_q.period} :
    ra == uaddr(ppgc_pkg::PPGC_OFS_U1, 3'h1) ? {16'h0000, u1_q.rise_a} :
    ra == uaddr(ppgc_pkg::PPGC_OFS_U1, 3'h2) ? {16'h0000, u1_q.fall_a} :
    ra == uaddr(ppgc_pkg::PPGC_OFS_U1, 3'h3) ? {16'h0000, u1_q.rise_b} :
    ra == uaddr(ppgc_pkg::PPGC_OFS_U1, 3'h4) ? {16'h0000, u1_q.fall_b} :
    32'h0000_0000;

  // Event selection; overflow codes are decoded to nothing
  wire s0_d = (sel0 == ppgc_pkg::PPGC_SEL_PERIOD && m0[0]) ||
              (sel0 == ppgc_pkg::PPGC_SEL_PHASE && phase_hit);
  wire s1_d = sel1 == ppgc_pkg::PPGC_SEL_PERIOD && m1[0] && !ilock;

  // Software registers and bus handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= ppgc_pkg::PPGC_RST_CTRL;
      phase_q   <= ppgc_pkg::PPGC_RST_CMP;
      u0_q      <= {5{ppgc_pkg::PPGC_RST_CMP}};
      u1_q      <= {5{ppgc_pkg::PPGC_RST_CMP}};
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= ppgc_pkg::PPGC_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= ppgc_pkg::PPGC_RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      ctrl_q    <= ctrl_d;
      phase_q   <= phase_d;
      u0_q      <= u0_d;
      u1_q      <= u1_d;
      awready_q <= wr_go;
      arready_q <= rd_go;
      if (wr_hit) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? ppgc_pkg::PPGC_RESP_OKAY
                          : ppgc_pkg::PPGC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_hit) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_data;
        rresp_q  <= rd_ok ? ppgc_pkg::PPGC_RESP_OKAY
                          : ppgc_pkg::PPGC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Request pulses, one cycle after the match they report
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_s0_q <= 1'b0;
      irq_s1_q <= 1'b0;
      irq_f0_q <= 4'h0;
      irq_f1_q <= 4'h0;
    end else begin
      irq_s0_q <= s0_d;
      irq_s1_q <= s1_d;
      irq_f0_q <= m0[4:1];
      irq_f1_q <= m1[4:1];
    end
  end

  // Unit 0 always free-runs on its own period
  ppgc_unit u_unit0 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (run0),
    .wrap_en  (1'b1),
    .restart  (1'b0),
    .cmp      (u0_q),
    .cnt_q    (cnt0),
    .wave_a_q (programmable_pulse_output[0]),
    .wave_b_q (programmable_pulse_output[1]),
    .match    (m0)
  );

  // Unit 1 ignores its period in interlock and follows phase
  ppgc_unit u_unit1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (run1),
    .wrap_en  (!ilock),
    .restart  (ilock && phase_hit),
    .cmp      (u1_q),
    .cnt_q    (cnt1),
    .wave_a_q (programmable_pulse_output[2]),
    .wave_b_q (programmable_pulse_output[3]),
    .match    (m1)
  );

  assign s_axi_awready        = awready_q;
  assign s_axi_wready         = awready_q;
  assign s_axi_bvalid         = bvalid_q;
  assign s_axi_bresp          = bresp_q;
  assign s_axi_arready        = arready_q;
  assign s_axi_rvalid         = rvalid_q;
  assign s_axi_rresp          = rresp_q;
  assign s_axi_rdata          = rdata_q;
  assign unit0_selectable_irq = irq_s0_q;
  assign unit1_selectable_irq = irq_s1_q;
  assign unit0_fixed_irq      = irq_f0_q;
  assign unit1_fixed_irq      = irq_f1_q;

  sel0_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_s0_q == $past((sel0 == 2'b01 && m0[0]) ||
                      (sel0 == 2'b10 && phase_hit)))
    else $error("unit 0 selectable request wrong");
  sel0_ovf_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sel0 == 2'b11 |=> !irq_s0_q)
    else $error("unit 0 overflow code raised a request");
  sel1_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_s1_q |-> $past(!ilock && sel1 == 2'b01 && m1[0]))
    else $error("unit 1 selectable request wrong");
  fixed_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_f0_q == $past(m0[4:1]) && irq_f1_q == $past(m1[4:1]))
    else $error("fixed request does not follow its match");
  ilock_phase_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ilock && phase_hit ##1 ilock && run0 |-> cnt1 == 16'h0001)
    else $error("unit 1 not restarted by phase match");
  irq_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_s0_q && sel0 == 2'b01 && u0_q.period != 16'h0001 &&
    $stable(u0_q) |=> !irq_s0_q)
    else $error("period request longer than one cycle");
  bus_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_hit |=> s_axi_bvalid)
    else $error("write not answered");
endmodule  // ppgc_top

// ==== dv/ppgc_top_bench.sv ====
// Self-checking bench for the two-unit pulse generator and its event select
`timescale 1ns/1ps
module ppgc_top_bench;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [3:0]  wave;
  logic        sel0_irq;
  logic        sel1_irq;
  logic [3:0]  fix0_irq;
  logic [3:0]  fix1_irq;
  int          mismatches;
  int          comparisons;
  int          hi [4];
  int          f0 [4];
  int          f1 [4];
  int          s0;
  int          s1;
  logic [31:0] rd;
  logic [1:0]  rsp;

  ppgc_top u_dut (
    .aclk                      (aclk),
    .aresetn                   (aresetn),
    .s_axi_awaddr              (awaddr),
    .s_axi_awvalid             (awvalid),
    .s_axi_awready             (awready),
    .s_axi_wdata               (wdata),
    .s_axi_wstrb               (wstrb),
    .s_axi_wvalid              (wvalid),
    .s_axi_wready              (wready),
    .s_axi_bresp               (bresp),
    .s_axi_bvalid              (bvalid),
    .s_axi_bready              (bready),
    .s_axi_araddr              (araddr),
    .s_axi_arvalid             (arvalid),
    .s_axi_arready             (arready),
    .s_axi_rdata               (rdata),
    .s_axi_rresp               (rresp),
    .s_axi_rvalid              (rvalid),
    .s_axi_rready              (rready),
    .programmable_pulse_output (wave),
    .unit0_selectable_irq      (sel0_irq),
    .unit1_selectable_irq      (sel1_irq),
    .unit0_fixed_irq           (fix0_irq),
    .unit1_fixed_irq           (fix1_irq)
  );

  // 100 ns clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Compare helper; unknowns never pass
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Single write; each channel is held until its own ready edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    bit aw_done;
    bit w_done;
    n       = 0;
    aw_done = 1'b0;
    w_done  = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done) && n < 50);
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) chk(32'h0000_0001, 32'h0000_0000, "write stalled");
    r = bresp;
    bready <= 1'b0;
    // Idle edge so a following call never reassigns bready in this step
    @(posedge aclk);
  endtask

  // Single read; data taken at the edge where rvalid is seen
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) chk(32'h0000_0001, 32'h0000_0000, "read stalled");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // Idle edge so a following call never reassigns rready in this step
    @(posedge aclk);
  endtask

  // Counts high cycles of waves and requests over a window, mid-cycle
  task automatic measure(input int cycles);
    for (int i = 0; i < 4; i++) begin
      hi[i] = 0;
      f0[i] = 0;
      f1[i] = 0;
    end
    s0 = 0;
    s1 = 0;
    repeat (cycles) begin
      @(negedge aclk);
      for (int i = 0; i < 4; i++) begin
        hi[i] += (wave[i] === 1'b1);
        f0[i] += (fix0_irq[i] === 1'b1);
        f1[i] += (fix1_irq[i] === 1'b1);
      end
      s0 += (sel0_irq === 1'b1);
      s1 += (sel1_irq === 1'b1);
    end
  endtask

  // Reset values, unmapped place and read-only status
  task automatic t_reset;
    axi_rd(8'h00, rd, rsp);
    chk(rd, 32'h0000_0000, "ctrl reset");
    axi_rd(8'h04, rd, rsp);
    chk(rd, 32'h0000_0000, "status reset, counters stopped");
    axi_rd(8'h10, rd, rsp);
    chk(rd, 32'h0000_0000, "period reset");
    axi_rd(8'h08, rd, rsp);
    chk(rd, 32'h0000_0000, "unmapped rd data");
    chk({30'h0, rsp}, {30'h0, ppgc_pkg::PPGC_RESP_SLVERR}, "unmapped rd");
    axi_wr(8'h04, 32'h0000_FFFF, rsp);
    chk({30'h0, rsp}, {30'h0, ppgc_pkg::PPGC_RESP_SLVERR}, "status write");
  endtask

  // Legal compares: rise below fall, fall within period, phase below half
  task automatic t_program;
    axi_wr(8'h10, 32'h0000_000A, rsp);
    axi_wr(8'h14, 32'h0000_0002, rsp);
    axi_wr(8'h18, 32'h0000_0006, rsp);
    axi_wr(8'h1C, 32'h0000_0003, rsp);
    axi_wr(8'h20, 32'h0000_0009, rsp);
    axi_wr(8'h24, 32'h0000_0008, rsp);
    axi_wr(8'h30, 32'h0000_000C, rsp);
    axi_wr(8'h34, 32'h0000_0001, rsp);
    axi_wr(8'h38, 32'h0000_0004, rsp);
    axi_wr(8'h3C, 32'h0000_0005, rsp);
    axi_wr(8'h40, 32'h0000_000B, rsp);
    axi_rd(8'h24, rd, rsp);
    chk(rd, 32'h0000_0008, "phase field readback");
  endtask

  // Every select code in both modes; window of 60 holds whole periods
  task automatic t_modes;
    logic [31:0] ctrl;
    int          e0;
    int          e1;
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        ctrl = 32'h0000_0003 | (c << 6) | (c << 4) | (m << 2);
        axi_wr(8'h00, ctrl, rsp);
        measure(60);
        measure(60);
        e0 = (c == 1 || c == 2) ? 6 : 0;
        e1 = (c == 1 && m == 0) ? 5 : 0;
        chk(s0, e0, "unit0 select events");
        chk(s1, e1, "unit1 select events");
        chk(hi[0], 24, "unit0 wave A duty");
        chk(hi[1], 36, "unit0 wave B duty");
        chk(f0[0] + f0[1] + f0[2] + f0[3], 24, "unit0 fixed");
        chk(f1[0] + f1[1], m ? 12 : 10, "unit1 fixed");
        chk(f1[2] + f1[3], m ? 6 : 10, "unit1 fixed B");
        chk(hi[2], m ? 18 : 15, "unit1 wave A duty");
        if (m == 0) chk(hi[3], 30, "unit1 wave B duty");
      end
    end
    axi_rd(8'h30, rd, rsp);
    chk(rd, 32'h0000_000C, "unit1 period kept");
    axi_wr(8'h00, 32'h0000_0000, rsp);
    measure(20);
    chk(hi[0] + s0 + f0[0], 0, "stopped unit quiet");
  endtask

  // Report counts and verdict, then end the run
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog well above the expected run of just over a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end

  // Main sequence
  initial begin
    mismatches  = 0;
    comparisons = 0;
    aresetn = 1'b0;
    awaddr  = 8'h00;
    awvalid = 1'b0;
    wdata   = 32'h0000_0000;
    wstrb   = 4'h0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h00;
    arvalid = 1'b0;
    rready  = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_program();
    t_modes();
    give_verdict();
  end
endmodule // ppgc_top_bench
